// [ccu_map.svh]
`ifndef CCU_MAP_SVH
`define CCU_MAP_SVH

// per-unit registers: address {1'b0, unit[1:0], index[1:0]}
`define IDX_UNIT_CONTROL 2'h0
`define IDX_CAPTURE_SOURCE 2'h1
`define IDX_HOLD_LOW 2'h2
`define IDX_HOLD_HIGH 2'h3

// shared registers
`define OFF_FLAG_REG 5'h10
`define OFF_ENABLE_REG 5'h11
`define OFF_TIMER_CTRL 5'h12
`define OFF_TIMER_LOW 5'h13
`define OFF_TIMER_HIGH 5'h14

// unit_control fields
`define CTRL_EN_BIT 7
`define CTRL_OUT_BIT 5
`define CTRL_MODE_LSB 0
`define CTRL_MODE_MSB 3

// timer control fields
`define TCTRL_ON_BIT 0
`define TCTRL_EXT_BIT 1

// reset values
`define RST_BYTE 8'h00
`define RST_HOLD 16'h0000
`define RST_PRESC 4'h0

// timing counts
`define INSTR_DIV_LAST 2'h3
`define PRESC4_MASK 4'h3
`define PRESC16_MASK 4'hF

`endif

// [ccu_pkg.sv]
`default_nettype none

package ccu_pkg;

   typedef enum logic [3:0] {
      MODE_OFF = 4'h0,
      MODE_CMP_TOGGLE_CLR = 4'h1,
      MODE_CMP_TOGGLE = 4'h2,
      MODE_CAP_ANY = 4'h3,
      MODE_CAP_FALL = 4'h4,
      MODE_CAP_RISE = 4'h5,
      MODE_CAP_4TH = 4'h6,
      MODE_CAP_16TH = 4'h7,
      MODE_CMP_SET = 4'h8,
      MODE_CMP_CLEAR = 4'h9,
      MODE_CMP_SWINT = 4'hA,
      MODE_CMP_PULSE = 4'hB
   } mode_e;

   typedef enum logic [1:0] {
      SRC_PIN,
      SRC_CMP_ONE,
      SRC_CMP_TWO,
      SRC_PIN_CHANGE
   } src_e;

   function automatic logic is_capture(input mode_e m);
      return (m == MODE_CAP_ANY) || (m == MODE_CAP_FALL) || (m == MODE_CAP_RISE) ||
             (m == MODE_CAP_4TH) || (m == MODE_CAP_16TH);
   endfunction : is_capture

   function automatic logic is_compare(input mode_e m);
      return (m == MODE_CMP_TOGGLE_CLR) || (m == MODE_CMP_TOGGLE) || (m == MODE_CMP_SET) ||
             (m == MODE_CMP_CLEAR) || (m == MODE_CMP_SWINT) || (m == MODE_CMP_PULSE);
   endfunction : is_compare

   function automatic logic resets_timer(input mode_e m);
      return (m == MODE_CMP_TOGGLE_CLR) || (m == MODE_CMP_PULSE);
   endfunction : resets_timer

endpackage : ccu_pkg

`default_nettype wire

// [base_timer_if.sv]
`default_nettype none

interface base_timer_if;
   logic [15:0] value;
   logic clear_req;
   logic load_low;
   logic load_high;
   logic [7:0] load_data;
   logic run;
   logic ext_sel;
   logic sleep;
   logic ext_clk;

   modport timer (
      input clear_req, load_low, load_high, load_data, run, ext_sel, sleep, ext_clk,
      output value
   );
   modport user (
      output clear_req, load_low, load_high, load_data, run, ext_sel, sleep, ext_clk,
      input value
   );
endinterface : base_timer_if

`default_nettype wire

// [base_timer.sv]
`include "ccu_map.svh"
`default_nettype none

module base_timer
   import ccu_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // timer link
   base_timer_if.timer tif
);

   logic [1:0] div_ff, nxt_div;
   logic ext_prev_ff, nxt_ext_prev;
   logic [15:0] count_ff, nxt_count;
   logic tick;

   always_comb begin
      nxt_div = div_ff;
      nxt_ext_prev = tif.ext_clk;
      tick = 1'b0;
      // instruction clock halts in sleep and the count is simply held
      if (tif.run && !tif.ext_sel && !tif.sleep) begin
         nxt_div = div_ff + 2'h1;
         tick = (div_ff == `INSTR_DIV_LAST);
      end
      // external clock keeps counting in sleep, so capture still works
      if (tif.run && tif.ext_sel && tif.ext_clk && !ext_prev_ff) begin
         tick = 1'b1;
      end
      nxt_count = count_ff;
      if (tick) begin
         nxt_count = count_ff + 16'h0001;
      end
      if (tif.clear_req) begin
         nxt_count = 16'h0000;
      end
      if (tif.load_low) begin
         nxt_count[7:0] = tif.load_data;
      end
      if (tif.load_high) begin
         nxt_count[15:8] = tif.load_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         div_ff <= 2'h0;
         ext_prev_ff <= 1'b0;
         count_ff <= 16'h0000;
      end else begin
         div_ff <= nxt_div;
         ext_prev_ff <= nxt_ext_prev;
         count_ff <= nxt_count;
      end
   end

   assign tif.value = count_ff;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sleep_hold_a: assert property (
      (tif.sleep && !tif.ext_sel && !tif.clear_req && !tif.load_low && !tif.load_high)
      |=> $stable(count_ff))
      else $error("timer moved during sleep on instruction clock");

endmodule : base_timer

`default_nettype wire

// [timer_capture_compare_unit.sv]
`include "ccu_map.svh"
`default_nettype none

// Overview of operation
// - two identical units, each with control, holding pair, flag and pin
// - a capture copies the whole 16-bit timer into the holding pair
// - mode picks any edge, falling, rising, every 4th or 16th rise
// - source select picks pin, comparator one, comparator two or pin change
// - each capture sets the unit flag; only software clears it
// - a later capture silently overwrites an unread earlier one
// - prescaler clears when disabled, outside capture mode, or in reset
// - switching prescale settings keeps the count; software disables first
// - every capture raises the event output for exactly one clock
// - the event output feeds waveform, converter, timers, measurement, logic
// - instruction-clocked timer holds in sleep; external clock keeps counting
// - compare mode checks holding pair against timer and acts on equality
// - a match sets the flag in the same cycle as the pin action
// - pulse modes hold the output high while timer equals holding pair
// - codes 0001 and 0010 toggle, 1001 clears, 1000 sets
// - software interrupt compare mode leaves the pin undriven
module timer_capture_compare_unit
   import ccu_pkg::*;
#(
   parameter int NUM_UNITS = 2
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // register port
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // power and timer clock
   input wire logic sleep,
   input wire logic ext_timer_clk,
   // capture sources
   input wire logic [NUM_UNITS-1:0] unit_pin_in,
   input wire logic comparator_one_synced,
   input wire logic comparator_two_synced,
   input wire logic pin_change_trigger,
   // pin drive, events and flags
   output logic [NUM_UNITS-1:0] unit_pin_out,
   output logic [NUM_UNITS-1:0] unit_pin_oe,
   output logic [NUM_UNITS-1:0] unit_event_out,
   output logic [NUM_UNITS-1:0] unit_event_flag
);

   base_timer_if tif ();

   base_timer u_timer (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .tif(tif.timer)
   );

   // per-unit state, indexed by unit number
   logic en_ff [NUM_UNITS], nxt_en [NUM_UNITS];
   mode_e mode_ff [NUM_UNITS], nxt_mode [NUM_UNITS];
   src_e src_ff [NUM_UNITS], nxt_src [NUM_UNITS];
   logic [15:0] hold_ff [NUM_UNITS], nxt_hold [NUM_UNITS];
   logic [3:0] presc_ff [NUM_UNITS], nxt_presc [NUM_UNITS];
   logic [NUM_UNITS-1:0] sync1_ff, nxt_sync1, sync2_ff, nxt_sync2, prev_ff, nxt_prev;
   logic [NUM_UNITS-1:0] eq_prev_ff, nxt_eq_prev, cmp_out_ff, nxt_cmp_out;
   logic [NUM_UNITS-1:0] event_ff, nxt_event, oe_ff, nxt_oe, flag_ff, nxt_flag;
   logic [NUM_UNITS-1:0] ie_ff, nxt_ie;
   logic [NUM_UNITS-1:0] rise, fall, cap_mode, cap_hit, eq, match_start;
   // shared state
   logic run_ff, nxt_run, ext_sel_ff, nxt_ext_sel;
   logic [7:0] rdata_ff, nxt_rdata;
   logic timer_clear;

   function automatic logic unit_reg(input logic [4:0] a, input int u, input logic [1:0] idx);
      return (a[4] == 1'b0) && (a[3:2] == u[1:0]) && (a[1:0] == idx);
   endfunction : unit_reg

   function automatic logic src_level(input src_e s, input logic pin, input logic c1,
                                      input logic c2, input logic ioc);
      case (s)
         SRC_PIN: return pin;
         SRC_CMP_ONE: return c1;
         SRC_CMP_TWO: return c2;
         default: return ioc;
      endcase
   endfunction : src_level

   always_comb begin
      timer_clear = 1'b0;
      for (int u = 0; u < NUM_UNITS; u++) begin
         nxt_en[u] = en_ff[u];
         nxt_mode[u] = mode_ff[u];
         nxt_src[u] = src_ff[u];
         nxt_hold[u] = hold_ff[u];
         nxt_flag[u] = flag_ff[u];
         nxt_ie[u] = ie_ff[u];
         // selected source first passes two flops, then an edge detector
         nxt_sync1[u] = src_level(src_ff[u], unit_pin_in[u], comparator_one_synced,
                                  comparator_two_synced, pin_change_trigger);
         nxt_sync2[u] = sync1_ff[u];
         nxt_prev[u] = sync2_ff[u];
         rise[u] = sync2_ff[u] && !prev_ff[u];
         fall[u] = !sync2_ff[u] && prev_ff[u];
         cap_mode[u] = en_ff[u] && is_capture(mode_ff[u]);
         // prescaler only counts rises; 4th and 16th share it, so a switch keeps it
         nxt_presc[u] = presc_ff[u];
         if (!cap_mode[u]) begin
            nxt_presc[u] = `RST_PRESC;
         end else if (rise[u] && (mode_ff[u] == MODE_CAP_4TH ||
                                  mode_ff[u] == MODE_CAP_16TH)) begin
            nxt_presc[u] = presc_ff[u] + 4'h1;
         end
         case (mode_ff[u])
            MODE_CAP_ANY: cap_hit[u] = rise[u] || fall[u];
            MODE_CAP_FALL: cap_hit[u] = fall[u];
            MODE_CAP_RISE: cap_hit[u] = rise[u];
            MODE_CAP_4TH: cap_hit[u] = rise[u] && ((presc_ff[u] & `PRESC4_MASK) == `PRESC4_MASK);
            MODE_CAP_16TH: cap_hit[u] = rise[u] && (presc_ff[u] == `PRESC16_MASK);
            default: cap_hit[u] = 1'b0;
         endcase
         cap_hit[u] = cap_hit[u] && en_ff[u];
         // compare: level of equality, with its first cycle as the match event
         eq[u] = en_ff[u] && is_compare(mode_ff[u]) && (hold_ff[u] == tif.value);
         nxt_eq_prev[u] = eq[u];
         match_start[u] = eq[u] && !eq_prev_ff[u];
         nxt_cmp_out[u] = cmp_out_ff[u];
         if (!en_ff[u]) begin
            nxt_cmp_out[u] = 1'b0;
         end else begin
            case (mode_ff[u])
               MODE_CMP_TOGGLE_CLR, MODE_CMP_TOGGLE: begin
                  if (match_start[u]) nxt_cmp_out[u] = !cmp_out_ff[u];
               end
               MODE_CMP_SET: begin
                  if (match_start[u]) nxt_cmp_out[u] = 1'b1;
               end
               MODE_CMP_CLEAR: begin
                  if (match_start[u]) nxt_cmp_out[u] = 1'b0;
               end
               // output high while equal; in pulse mode the match clears the timer, which ends the pulse
               MODE_CMP_SWINT, MODE_CMP_PULSE: nxt_cmp_out[u] = eq[u];
               default: nxt_cmp_out[u] = cmp_out_ff[u];
            endcase
         end
         if (match_start[u] && resets_timer(mode_ff[u])) begin
            timer_clear = 1'b1;
         end
         // pin is driven only in compare modes other than software interrupt
         nxt_oe[u] = en_ff[u] && is_compare(mode_ff[u]) && (mode_ff[u] != MODE_CMP_SWINT);
         // one shared output feeds every on-chip consumer
         nxt_event[u] = cap_mode[u] ? cap_hit[u] : nxt_cmp_out[u];
         // register writes
         if (reg_wr && unit_reg(reg_addr, u, `IDX_UNIT_CONTROL)) begin
            nxt_en[u] = reg_wdata[`CTRL_EN_BIT];
            nxt_mode[u] = mode_e'(reg_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
         end
         if (reg_wr && unit_reg(reg_addr, u, `IDX_CAPTURE_SOURCE)) begin
            nxt_src[u] = src_e'(reg_wdata[1:0]);
         end
         if (reg_wr && unit_reg(reg_addr, u, `IDX_HOLD_LOW)) begin
            nxt_hold[u][7:0] = reg_wdata;
         end
         if (reg_wr && unit_reg(reg_addr, u, `IDX_HOLD_HIGH)) begin
            nxt_hold[u][15:8] = reg_wdata;
         end
         // a capture overwrites whatever stands there, unread or not
         if (cap_hit[u]) begin
            nxt_hold[u] = tif.value;
         end
         if (reg_wr && reg_addr == `OFF_ENABLE_REG) begin
            nxt_ie[u] = reg_wdata[u];
         end
         // write one clears; a new event in the same cycle wins
         if (reg_wr && reg_addr == `OFF_FLAG_REG && reg_wdata[u]) begin
            nxt_flag[u] = 1'b0;
         end
         if (cap_hit[u]) begin
            nxt_flag[u] = 1'b1;
         end
         if (match_start[u]) begin
            nxt_flag[u] = 1'b1;
         end
      end
   end

   // shared registers and read path
   always_comb begin
      nxt_run = run_ff;
      nxt_ext_sel = ext_sel_ff;
      if (reg_wr && reg_addr == `OFF_TIMER_CTRL) begin
         nxt_run = reg_wdata[`TCTRL_ON_BIT];
         nxt_ext_sel = reg_wdata[`TCTRL_EXT_BIT];
      end
      nxt_rdata = `RST_BYTE;
      if (reg_rd) begin
         case (reg_addr)
            `OFF_FLAG_REG: nxt_rdata = 8'(flag_ff);
            `OFF_ENABLE_REG: nxt_rdata = 8'(ie_ff);
            `OFF_TIMER_CTRL: nxt_rdata = {6'h00, ext_sel_ff, run_ff};
            `OFF_TIMER_LOW: nxt_rdata = tif.value[7:0];
            `OFF_TIMER_HIGH: nxt_rdata = tif.value[15:8];
            default: nxt_rdata = `RST_BYTE;
         endcase
         for (int u = 0; u < NUM_UNITS; u++) begin
            if (unit_reg(reg_addr, u, `IDX_UNIT_CONTROL)) begin
               nxt_rdata = {en_ff[u], 1'b0, cmp_out_ff[u], 1'b0, 4'(mode_ff[u])};
            end
            if (unit_reg(reg_addr, u, `IDX_CAPTURE_SOURCE)) begin
               nxt_rdata = {6'h00, 2'(src_ff[u])};
            end
            if (unit_reg(reg_addr, u, `IDX_HOLD_LOW)) begin
               nxt_rdata = hold_ff[u][7:0];
            end
            if (unit_reg(reg_addr, u, `IDX_HOLD_HIGH)) begin
               nxt_rdata = hold_ff[u][15:8];
            end
         end
      end
   end

   always_comb begin
      tif.clear_req = timer_clear;
      tif.load_low = reg_wr && (reg_addr == `OFF_TIMER_LOW);
      tif.load_high = reg_wr && (reg_addr == `OFF_TIMER_HIGH);
      tif.load_data = reg_wdata;
      tif.run = run_ff;
      tif.ext_sel = ext_sel_ff;
      tif.sleep = sleep;
      tif.ext_clk = ext_timer_clk;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         for (int u = 0; u < NUM_UNITS; u++) begin
            en_ff[u] <= 1'b0;
            mode_ff[u] <= MODE_OFF;
            src_ff[u] <= SRC_PIN;
            hold_ff[u] <= `RST_HOLD;
            presc_ff[u] <= `RST_PRESC;
         end
         sync1_ff <= '0;
         sync2_ff <= '0;
         prev_ff <= '0;
         eq_prev_ff <= '0;
         cmp_out_ff <= '0;
         event_ff <= '0;
         oe_ff <= '0;
         flag_ff <= '0;
         ie_ff <= '0;
         run_ff <= 1'b0;
         ext_sel_ff <= 1'b0;
         rdata_ff <= `RST_BYTE;
      end else begin
         for (int u = 0; u < NUM_UNITS; u++) begin
            en_ff[u] <= nxt_en[u];
            mode_ff[u] <= nxt_mode[u];
            src_ff[u] <= nxt_src[u];
            hold_ff[u] <= nxt_hold[u];
            presc_ff[u] <= nxt_presc[u];
         end
         sync1_ff <= nxt_sync1;
         sync2_ff <= nxt_sync2;
         prev_ff <= nxt_prev;
         eq_prev_ff <= nxt_eq_prev;
         cmp_out_ff <= nxt_cmp_out;
         event_ff <= nxt_event;
         oe_ff <= nxt_oe;
         flag_ff <= nxt_flag;
         ie_ff <= nxt_ie;
         run_ff <= nxt_run;
         ext_sel_ff <= nxt_ext_sel;
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;
   assign unit_pin_out = cmp_out_ff;
   assign unit_pin_oe = oe_ff;
   assign unit_event_out = event_ff;
   assign unit_event_flag = flag_ff;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   for (genvar g = 0; g < NUM_UNITS; g++) begin : g_chk
      capture_latch_a: assert property (
         cap_hit[g] |=> (hold_ff[g] == $past(tif.value)))
         else $error("holding pair did not take the timer value");
      capture_pulse_a: assert property (
         (cap_mode[g] && !cap_hit[g]) |=> !event_ff[g])
         else $error("capture event output longer than one clock");
      capture_flag_a: assert property (
         cap_hit[g] |=> flag_ff[g] ##1 (flag_ff[g] || $past(reg_wr)))
         else $error("capture flag not set or dropped without a write");
      presc_clear_a: assert property (
         !cap_mode[g] |=> (presc_ff[g] == 4'h0))
         else $error("prescaler not cleared outside capture");
      match_flag_a: assert property (
         match_start[g] |=> (flag_ff[g]
            && ($past(mode_ff[g]) != MODE_CMP_SET || cmp_out_ff[g])
            && ($past(mode_ff[g]) != MODE_CMP_CLEAR || !cmp_out_ff[g])))
         else $error("match did not set the flag with the pin action");
      toggle_match_a: assert property (
         (match_start[g] && (mode_ff[g] == MODE_CMP_TOGGLE))
         |=> (cmp_out_ff[g] != $past(cmp_out_ff[g])))
         else $error("toggle mode did not toggle on match");
      swint_pin_a: assert property (
         (mode_ff[g] == MODE_CMP_SWINT) |=> !oe_ff[g])
         else $error("pin driven in software interrupt mode");
      pulse_level_a: assert property (
         (en_ff[g] && mode_ff[g] == MODE_CMP_PULSE) |=> (cmp_out_ff[g] == $past(eq[g])))
         else $error("pulse output does not follow equality");
   end

endmodule : timer_capture_compare_unit

`default_nettype wire

// [event_sources.sv]
`default_nettype none

module event_sources (
   // clock
   input wire logic clk_sys,
   // source lines
   output logic [1:0] pin_lvl,
   output logic cmp_one,
   output logic cmp_two,
   output logic pin_chg,
   output logic ext_clk
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      pin_lvl = 2'h0;
      cmp_one = 1'b0;
      cmp_two = 1'b0;
      pin_chg = 1'b0;
      ext_clk = 1'b0;
   end

   // lines change only on a system clock edge, so the counter mode stays synchronous
   task automatic set_line(input int sel, input int u, input logic v, input int hold);
      @(posedge clk_sys);
      case (sel)
         0: pin_lvl[u] <= v;
         1: cmp_one <= v;
         2: cmp_two <= v;
         default: pin_chg <= v;
      endcase
      repeat (hold) @(posedge clk_sys);
   endtask : set_line

   // external timer clock runs only on request, four system clocks a period
   task automatic ext_pulses(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         ext_clk <= 1'b1;
         repeat (2) @(posedge clk_sys);
         ext_clk <= 1'b0;
         @(posedge clk_sys);
      end
      repeat (2) @(posedge clk_sys);
   endtask : ext_pulses

endmodule : event_sources

`default_nettype wire

// [timer_capture_compare_unit_bench.sv]
`include "ccu_map.svh"
`default_nettype none

module timer_capture_compare_unit_bench;
   import ccu_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   localparam mode_e CAP_M [5] = '{MODE_CAP_ANY, MODE_CAP_FALL, MODE_CAP_RISE,
      MODE_CAP_4TH, MODE_CAP_16TH};
   localparam logic [15:0] CAP_N [5] = '{16'h0020, 16'h0010, 16'h0010, 16'h0004, 16'h0001};
   localparam mode_e CMP_M [7] = '{MODE_CMP_TOGGLE, MODE_CMP_TOGGLE_CLR, MODE_CMP_SET,
      MODE_CMP_CLEAR, MODE_CMP_SET, MODE_CMP_SWINT, MODE_CMP_PULSE};

   logic clk_sys = 1'b0;
   logic rst_n;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic sleep;
   logic ext_clk, cmp_one, cmp_two, pin_chg;
   logic [1:0] src_pin, pin_w, pin_out, pin_oe, ev_out, flag;
   logic [15:0] exp_q[$];
   logic [15:0] e;
   logic rd_d = 1'b0;
   logic cap_chk = 1'b0;
   logic [1:0] ev_prev = 2'h0;
   int ev_cnt[2] = '{0, 0};
   int error_cnt = 0;
   int checked = 0;

   always #25 clk_sys = ~clk_sys;

   // pin level seen by the unit: its own drive wins while enabled
   assign pin_w = (pin_oe & pin_out) | (~pin_oe & src_pin);

   timer_capture_compare_unit #(.NUM_UNITS(2)) i_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep(sleep),
      .ext_timer_clk(ext_clk), .unit_pin_in(pin_w), .comparator_one_synced(cmp_one),
      .comparator_two_synced(cmp_two), .pin_change_trigger(pin_chg),
      .unit_pin_out(pin_out), .unit_pin_oe(pin_oe), .unit_event_out(ev_out),
      .unit_event_flag(flag));

   event_sources i_src (.clk_sys(clk_sys), .pin_lvl(src_pin), .cmp_one(cmp_one),
      .cmp_two(cmp_two), .pin_chg(pin_chg), .ext_clk(ext_clk));

   function automatic logic [4:0] ua(input int u, input logic [1:0] idx);
      return {1'b0, 2'(u), idx};
   endfunction : ua

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      @(posedge clk_sys);
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [7:0] d, input logic [7:0] m);
      reg_addr <= a;
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      exp_q.push_back({m, d & m});
      @(posedge clk_sys);
   endtask : rd

   task automatic cyc(input int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge clk_sys);
   endtask : cyc

   // hold of five or more edges lets the three-stage capture path finish first
   task automatic line(input int s, input int u, input logic v);
      cyc(0);
      i_src.set_line(s, u, v, 5 + $urandom_range(3));
   endtask : line

   task automatic rises(input int n);
      repeat (n) begin
         line(0, 0, 1'b1);
         line(0, 0, 1'b0);
      end
   endtask : rises

   task automatic set_timer(input logic [15:0] t);
      wr(`OFF_TIMER_CTRL, 8'h00);
      wr(`OFF_TIMER_LOW, t[7:0]);
      wr(`OFF_TIMER_HIGH, t[15:8]);
   endtask : set_timer

   always @(posedge clk_sys) begin
      if (rd_d) begin
         e = exp_q.pop_front();
         check({8'h00, reg_rdata & e[15:8]}, {8'h00, e[7:0]});
      end
      rd_d = reg_rd;
      for (int u = 0; u < 2; u++) begin
         if (cap_chk && ev_prev[u]) check({15'h0000, ev_out[u]}, 16'h0000);
         if (ev_out[u] === 1'b1 && ev_prev[u] !== 1'b1) ev_cnt[u]++;
      end
      ev_prev = ev_out;
   end

   initial begin
      #(50 * 90000);
      error_cnt++;
      print_verdict();
   end

   initial begin
      logic [15:0] t;
      int b;
      int k;
      int n;
      logic eo;
      logic ef;
      mode_e m;
      void'($urandom(4495));
      rst_n = 1'b0;
      reg_addr = 5'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      sleep = 1'b0;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      check({8'h00, pin_out, pin_oe, ev_out, flag}, 16'h0000);
      @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      for (int u = 0; u < 2; u++) begin
         for (int i = 0; i < 4; i++) rd(ua(u, 2'(i)), 8'h00, 8'hFF);
      end
      rd(`OFF_FLAG_REG, 8'h00, 8'hFF);
      wr(5'h1F, 8'hFF);
      rd(5'h1F, 8'h00, 8'hFF);
      wr(`OFF_ENABLE_REG, 8'h03);
      rd(`OFF_ENABLE_REG, 8'h03, 8'h03);
      cap_chk = 1'b1;
      for (int u = 0; u < 2; u++) begin
         for (int s = 0; s < 4; s++) begin
            wr(ua(u, `IDX_UNIT_CONTROL), {4'h8, MODE_CAP_RISE});
            wr(ua(u, `IDX_CAPTURE_SOURCE), 8'(s));
            wr(`OFF_FLAG_REG, 8'h03);
            b = ev_cnt[u];
            repeat (2) begin
               t = 16'($urandom);
               set_timer(t);
               line(s, u, 1'b1);
               line(s, u, 1'b0);
            end
            check(16'(ev_cnt[u] - b), 16'h0002);
            rd(ua(u, `IDX_HOLD_LOW), t[7:0], 8'hFF);
            rd(ua(u, `IDX_HOLD_HIGH), t[15:8], 8'hFF);
            rd(`OFF_FLAG_REG, 8'(1 << u), 8'h03);
         end
         wr(ua(u, `IDX_UNIT_CONTROL), 8'h00);
      end
      wr(ua(0, `IDX_CAPTURE_SOURCE), 8'h00);
      for (int i = 0; i < 5; i++) begin
         wr(ua(0, `IDX_UNIT_CONTROL), 8'h00);
         wr(ua(0, `IDX_UNIT_CONTROL), {4'h8, CAP_M[i]});
         b = ev_cnt[0];
         rises(16);
         check(16'(ev_cnt[0] - b), CAP_N[i]);
      end
      wr(ua(0, `IDX_UNIT_CONTROL), {4'h8, MODE_CAP_4TH});
      b = ev_cnt[0];
      rises(3);
      wr(ua(0, `IDX_UNIT_CONTROL), {4'h0, MODE_CAP_4TH});
      wr(ua(0, `IDX_UNIT_CONTROL), {4'h8, MODE_CAP_4TH});
      rises(1);
      check(16'(ev_cnt[0] - b), 16'h0000);
      rises(2);
      wr(ua(0, `IDX_UNIT_CONTROL), {4'h8, MODE_CAP_16TH});
      rises(12);
      check(16'(ev_cnt[0] - b), 16'h0000);
      rises(1);
      check(16'(ev_cnt[0] - b), 16'h0001);
      cap_chk = 1'b0;
      t = 16'($urandom) & 16'h7FFF | 16'h0001;
      wr(ua(0, `IDX_UNIT_CONTROL), 8'h00);
      wr(ua(0, `IDX_HOLD_LOW), t[7:0]);
      eo = 1'b0;
      for (int i = 0; i < 7; i++) begin
         m = CMP_M[i];
         // bit 7 flipped keeps the half-written timer from ever matching
         wr(ua(0, `IDX_HOLD_HIGH), t[15:8] ^ 8'h80);
         set_timer(t);
         wr(ua(0, `IDX_UNIT_CONTROL), {4'h8, m});
         wr(`OFF_FLAG_REG, 8'h01);
         wr(ua(0, `IDX_HOLD_HIGH), t[15:8]);
         cyc(0);
         for (k = 0; k < 10 && flag[0] !== 1'b1; k++) @(negedge clk_sys);
         ef = (m == MODE_CMP_SET || m == MODE_CMP_PULSE) ? 1'b1 :
              (m == MODE_CMP_CLEAR) ? 1'b0 : ~eo;
         check({15'h0000, flag[0]}, 16'h0001);
         if (m == MODE_CMP_SWINT) begin
            check({14'h0000, pin_oe[0], pin_out[0]}, 16'h0001);
         end else begin
            check({14'h0000, pin_oe[0], pin_out[0]}, {14'h0000, 1'b1, ef});
            eo = (m == MODE_CMP_PULSE) ? 1'b0 : ef;
         end
         @(posedge clk_sys);
         cyc(4);
         rd(ua(0, `IDX_UNIT_CONTROL), {2'h2, eo, 1'b0, m},
            (m == MODE_CMP_SWINT) ? 8'h8F : 8'hAF);
         rd(`OFF_FLAG_REG, 8'h01, 8'h01);
         if (m == MODE_CMP_TOGGLE_CLR || m == MODE_CMP_PULSE) begin
            rd(`OFF_TIMER_LOW, 8'h00, 8'hFF);
            rd(`OFF_TIMER_HIGH, 8'h00, 8'hFF);
         end
      end
      // unit 0 left in a timer-clearing compare mode would disturb the sleep count
      wr(ua(0, `IDX_UNIT_CONTROL), 8'h00);
      t = 16'($urandom);
      set_timer(t);
      sleep <= 1'b1;
      wr(`OFF_TIMER_CTRL, 8'h01);
      cyc(40);
      rd(`OFF_TIMER_LOW, t[7:0], 8'hFF);
      rd(`OFF_TIMER_HIGH, t[15:8], 8'hFF);
      n = 5 + $urandom_range(10);
      wr(`OFF_TIMER_CTRL, 8'h03);
      rd(`OFF_TIMER_CTRL, 8'h03, 8'hFF);
      wr(ua(1, `IDX_CAPTURE_SOURCE), 8'h00);
      wr(ua(1, `IDX_UNIT_CONTROL), {4'h8, MODE_CAP_RISE});
      cyc(0);
      i_src.ext_pulses(n);
      t = t + 16'(n);
      line(0, 1, 1'b1);
      line(0, 1, 1'b0);
      rd(ua(1, `IDX_HOLD_LOW), t[7:0], 8'hFF);
      rd(ua(1, `IDX_HOLD_HIGH), t[15:8], 8'hFF);
      sleep <= 1'b0;
      cyc(3);
      print_verdict();
   end

endmodule : timer_capture_compare_unit_bench

`default_nettype wire
